// file: logic/config_chain_device.sv
// Chained device end: loads the serial image, reports errors, enters user mode
`timescale 1ns/1ps
`include "config_chain_map.svh"
module config_chain_device
  import config_chain_pkg::*;
#(
  parameter int IMAGE_BITS  = `IMAGE_BITS_DEFAULT,
  parameter int INIT_CYCLES = `INIT_CYCLES_DEFAULT
)
(
  input  wire logic         REF_CLK_I,
  input  wire logic         RST_I,
  config_chain_if.device_mp LINK,
  input  wire logic         AUTO_RESTART_I,
  input  wire logic         USER_INIT_SEL_I,
  output logic              USER_MODE_O,
  output logic              CONFIG_ERROR_O
);

  localparam logic [15:0] TIMEOUT = 16'(`RESTART_TIMEOUT_CYCLES);
  localparam logic [15:0] LAST_BIT = 16'(IMAGE_BITS - 1);
  localparam logic [15:0] LAST_INIT = 16'(INIT_CYCLES - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       [6:0]  meta_reg;
  logic       [6:0]  sync_reg;
  logic       [1:0]  prev_reg;
  dev_state_t        state_reg;
  dev_state_t        state_next;
  logic       [15:0] cnt_reg;
  logic       [15:0] cnt_next;
  logic              parity_reg;
  logic              parity_next;
  logic              chain_out_reg;

  wire [6:0] raw_w = {LINK.chain_enable_in_n, LINK.user_init_clock, LINK.configuration_finished,
                      LINK.chain_error_status_n, LINK.serial_config_data, LINK.serial_config_clock,
                      LINK.config_request_n};

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      meta_reg <= 7'h7F;
      sync_reg <= 7'h7F;
      // Matches the synchroniser reset value, so no false clock edge follows reset
      prev_reg <= 2'h3;
    end
    else
    begin
      meta_reg <= raw_w;
      sync_reg <= meta_reg;
      prev_reg <= {sync_reg[5], sync_reg[1]};
    end
  end

  wire cfg_low_w    = ~sync_reg[0];
  wire sclk_rise_w  = sync_reg[1] & ~prev_reg[0];
  wire data_w       = sync_reg[2];
  wire status_hi_w  = sync_reg[3];
  wire done_hi_w    = sync_reg[4];
  wire uclk_rise_w  = sync_reg[5] & ~prev_reg[1];
  wire selected_w   = ~sync_reg[6];
  wire init_edge_w  = USER_INIT_SEL_I ? uclk_rise_w : sclk_rise_w;
  wire bit_take_w   = selected_w & sclk_rise_w;

  // ****************************************
  // Load, initialise and recover
  // ****************************************
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    parity_next = parity_reg;
    if (cfg_low_w)
    begin
      state_next = DEV_RESET;
      cnt_next   = 16'h0;
    end
    else
    begin
      case (state_reg)
        DEV_RESET:
          if (status_hi_w)
          begin
            state_next  = DEV_LOAD;
            cnt_next    = 16'h0;
            parity_next = 1'b0;
          end
        DEV_LOAD:
          if (!status_hi_w)
            state_next = DEV_HALT;
          else if (bit_take_w)
          begin
            parity_next = parity_reg ^ data_w;
            cnt_next    = cnt_reg + 16'h1;
            if (cnt_reg == LAST_BIT)
            begin
              cnt_next   = 16'h0;
              state_next = (parity_reg ^ data_w) ? DEV_ERROR : DEV_INIT;
            end
          end
        DEV_INIT:
          if (!status_hi_w)
            state_next = DEV_HALT;
          else if (done_hi_w && init_edge_w)
          begin
            cnt_next = cnt_reg + 16'h1;
            if (cnt_reg == LAST_INIT)
              state_next = DEV_USER;
          end
        DEV_ERROR:
        begin
          cnt_next = cnt_reg + 16'h1;
          if (AUTO_RESTART_I && cnt_reg == TIMEOUT - 16'h1)
            state_next = DEV_RESTART;
        end
        DEV_HALT:
          if (AUTO_RESTART_I && status_hi_w)
          begin
            state_next  = DEV_LOAD;
            cnt_next    = 16'h0;
            parity_next = 1'b0;
          end
        DEV_RESTART:
          if (status_hi_w)
          begin
            state_next  = DEV_LOAD;
            cnt_next    = 16'h0;
            parity_next = 1'b0;
          end
        default:
          state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_reg     <= DEV_RESET;
      cnt_reg       <= 16'h0;
      parity_reg    <= 1'b0;
      chain_out_reg <= 1'b1;
    end
    else
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      parity_reg    <= parity_next;
      chain_out_reg <= ~(state_next == DEV_INIT || state_next == DEV_USER);
    end
  end

  // ****************************************
  // Shared open-drain lines
  // ****************************************
  // Status is held low through the request pulse so the whole chain restarts together
  assign LINK.status_out         = 1'b0;
  assign LINK.status_oe          = (state_reg == DEV_RESET && cfg_low_w) || state_reg == DEV_ERROR;
  assign LINK.done_out           = 1'b0;
  assign LINK.done_oe            = ~(state_reg == DEV_INIT || state_reg == DEV_USER);
  assign LINK.chain_enable_out_n = chain_out_reg;
  assign USER_MODE_O             = state_reg == DEV_USER;
  assign CONFIG_ERROR_O          = state_reg == DEV_ERROR;

endmodule

// file: logic/config_chain_host.sv
// Configuration host end: drives request, serial clock and data for the whole chain
`timescale 1ns/1ps
`include "config_chain_map.svh"
module config_chain_host
  import config_chain_pkg::*;
#(
  parameter int SCLK_HALF  = `SCLK_HALF_DEFAULT,
  parameter int INIT_EXTRA = `INIT_EXTRA_DEFAULT
)
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  config_chain_if.host_mp  LINK,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [31:0] RDATA_O,
  output logic             IRQ_O
);

  localparam logic [15:0] PULSE_LAST = 16'(`CONFIG_LOW_CYCLES - 1);
  localparam logic [15:0] EXTRA      = 16'(INIT_EXTRA);
  localparam logic [7:0]  HALF_LAST  = 8'(SCLK_HALF - 1);

  host_state_t        state_reg;
  host_state_t        state_next;
  logic        [15:0] cnt_reg;
  logic        [15:0] cnt_next;
  logic        [7:0]  div_reg;
  logic        [7:0]  div_next;
  logic        [2:0]  bit_reg;
  logic        [2:0]  bit_next;
  logic               busy_reg;
  logic               busy_next;
  logic        [7:0]  shift_reg;
  logic        [7:0]  shift_next;
  logic        [7:0]  hold_reg;
  logic               full_reg;
  logic               full_next;
  logic               cfg_n_reg;
  logic               cfg_n_next;
  logic               sclk_reg;
  logic               sclk_next;
  logic               data_reg;
  logic               data_next;
  logic               uclk_reg;
  logic               uclk_next;
  logic        [2:1]  ctrl_reg;
  logic        [3:0]  irq_stat_reg;
  logic        [3:0]  irq_en_reg;
  logic        [3:0]  ev;
  logic               take;
  logic               flush;
  logic        [31:0] rdata_reg;
  logic        [1:0]  meta_reg;
  logic        [1:0]  sync_reg;

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_ctrl_w  = WR_I && ADDR_I == `REG_CTRL;
  wire wr_data_w  = WR_I && ADDR_I == `REG_DATA;
  wire wr_clr_w   = WR_I && ADDR_I == `REG_IRQ_CLR;
  wire wr_en_w    = WR_I && ADDR_I == `REG_IRQ_EN;
  wire start_w    = wr_ctrl_w && WDATA_I[`CTRL_START];
  wire auto_w     = ctrl_reg[`CTRL_AUTO];
  wire userclk_w  = ctrl_reg[`CTRL_USERCLK];
  wire status_s_w = sync_reg[0];
  wire done_s_w   = sync_reg[1];
  wire half_w     = div_reg == HALF_LAST;
  wire init_clk_w = userclk_w ? uclk_reg : sclk_reg;
  wire [31:0] rd_mux_w =
    (ADDR_I == `REG_CTRL)     ? {29'h0, ctrl_reg, 1'b0} :
    (ADDR_I == `REG_STATUS)   ? {25'h0, done_s_w, status_s_w, full_reg, 1'b0, state_reg} :
    (ADDR_I == `REG_IRQ_STAT) ? {28'h0, irq_stat_reg} :
    (ADDR_I == `REG_IRQ_EN)   ? {28'h0, irq_en_reg} : 32'h0;

  // ****************************************
  // Shared line synchronisers
  // ****************************************
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end
    else
    begin
      meta_reg <= {LINK.configuration_finished, LINK.chain_error_status_n};
      sync_reg <= meta_reg;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    bit_next   = bit_reg;
    busy_next  = busy_reg;
    shift_next = shift_reg;
    cfg_n_next = cfg_n_reg;
    sclk_next  = sclk_reg;
    data_next  = data_reg;
    uclk_next  = uclk_reg;
    take       = 1'b0;
    flush      = 1'b0;
    ev         = 4'h0;
    case (state_reg)
      H_IDLE, H_DONE, H_ERROR:
        if (start_w)
        begin
          state_next = H_PULSE;
          cnt_next   = 16'h0;
          cfg_n_next = 1'b0;
          sclk_next  = 1'b0;
          uclk_next  = 1'b0;
          flush      = 1'b1;
        end
        else if (state_reg == H_ERROR && auto_w && status_s_w)
        begin
          state_next     = H_SHIFT;
          busy_next      = 1'b0;
          ev[`IRQ_RESTART] = 1'b1;
        end
      H_PULSE:
      begin
        cnt_next = cnt_reg + 16'h1;
        if (cnt_reg == PULSE_LAST)
        begin
          cfg_n_next = 1'b1;
          state_next = H_WAIT;
        end
      end
      H_WAIT:
        if (status_s_w)
        begin
          state_next = H_SHIFT;
          busy_next  = 1'b0;
        end
      H_SHIFT:
        if (!status_s_w)
        begin
          state_next     = H_ERROR;
          sclk_next      = 1'b0;
          busy_next      = 1'b0;
          flush          = 1'b1;
          ev[`IRQ_ERROR] = 1'b1;
        end
        else if (done_s_w)
        begin
          state_next = H_INIT;
          cnt_next   = 16'h0;
          div_next   = 8'h0;
          busy_next  = 1'b0;
        end
        else if (!busy_reg)
        begin
          if (full_reg)
          begin
            take          = 1'b1;
            busy_next     = 1'b1;
            shift_next    = hold_reg;
            data_next     = hold_reg[0];
            bit_next      = 3'h0;
            div_next      = 8'h0;
            sclk_next     = 1'b0;
            ev[`IRQ_BYTE] = 1'b1;
          end
        end
        else
        begin
          div_next = div_reg + 8'h1;
          if (half_w)
          begin
            div_next = 8'h0;
            if (!sclk_reg)
              sclk_next = 1'b1;
            else
            begin
              sclk_next  = 1'b0;
              bit_next   = bit_reg + 3'h1;
              shift_next = {1'b0, shift_reg[7:1]};
              data_next  = shift_reg[1];
              if (bit_reg == 3'h7)
                busy_next = 1'b0;
            end
          end
        end
      H_INIT:
        if (!status_s_w)
        begin
          state_next     = H_ERROR;
          sclk_next      = 1'b0;
          uclk_next      = 1'b0;
          flush          = 1'b1;
          ev[`IRQ_ERROR] = 1'b1;
        end
        else
        begin
          div_next = div_reg + 8'h1;
          if (half_w)
          begin
            div_next = 8'h0;
            // Only one of the two clocks runs, so a device on the wrong source never counts
            if (userclk_w)
              uclk_next = ~uclk_reg;
            else
              sclk_next = ~sclk_reg;
            if (!init_clk_w)
              cnt_next = cnt_reg + 16'h1;
            else if (cnt_reg == EXTRA)
            begin
              state_next    = H_DONE;
              ev[`IRQ_USER] = 1'b1;
            end
          end
        end
      default:
        state_next = H_IDLE;
    endcase
  end

  // A data write while the holding byte is full is dropped; software waits for the byte event
  assign full_next = flush ? 1'b0 : take ? 1'b0 : (wr_data_w && !full_reg) ? 1'b1 : full_reg;

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_reg <= H_IDLE;
      cnt_reg   <= 16'h0;
      div_reg   <= 8'h0;
      bit_reg   <= 3'h0;
      busy_reg  <= 1'b0;
      shift_reg <= 8'h0;
      cfg_n_reg <= 1'b1;
      sclk_reg  <= 1'b0;
      data_reg  <= 1'b0;
      uclk_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      div_reg   <= div_next;
      bit_reg   <= bit_next;
      busy_reg  <= busy_next;
      shift_reg <= shift_next;
      cfg_n_reg <= cfg_n_next;
      sclk_reg  <= sclk_next;
      data_reg  <= data_next;
      uclk_reg  <= uclk_next;
    end
  end

  // ****************************************
  // Software registers and interrupt
  // ****************************************
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      hold_reg     <= 8'h0;
      full_reg     <= 1'b0;
      ctrl_reg     <= `CTRL_RESET;
      irq_stat_reg <= 4'h0;
      irq_en_reg   <= `IRQ_EN_RESET;
      rdata_reg    <= 32'h0;
    end
    else
    begin
      if (wr_data_w && !full_reg)
        hold_reg <= WDATA_I[7:0];
      full_reg <= full_next;
      if (wr_ctrl_w)
        ctrl_reg <= WDATA_I[2:1];
      if (wr_en_w)
        irq_en_reg <= WDATA_I[3:0];
      irq_stat_reg <= (irq_stat_reg & ~(wr_clr_w ? WDATA_I[3:0] : 4'h0)) | ev;
      rdata_reg    <= RD_I ? rd_mux_w : 32'h0;
    end
  end

  // ****************************************
  // Chain drive
  // ****************************************
  // Every line except chain_enable_in_n, which is tied low, leaves a flop, one buffer stage per drive point on the board
  assign LINK.config_request_n    = cfg_n_reg;
  assign LINK.serial_config_clock = sclk_reg;
  assign LINK.serial_config_data  = data_reg;
  assign LINK.user_init_clock     = uclk_reg;
  assign LINK.chain_enable_in_n   = 1'b0;
  assign RDATA_O                  = rdata_reg;
  assign IRQ_O                    = |(irq_stat_reg & irq_en_reg);

endmodule

// file: logic/config_chain_if.sv
// Shared configuration lines between the host and one chained device
`timescale 1ns/1ps
interface config_chain_if;
  logic config_request_n;
  logic serial_config_clock;
  logic serial_config_data;
  logic user_init_clock;
  logic chain_enable_in_n;
  logic chain_enable_out_n;
  logic status_out;
  logic status_oe;
  logic done_out;
  logic done_oe;
  logic chain_error_status_n;
  logic configuration_finished;

  // ****************************************
  // Open-drain lines with pull-ups
  // ****************************************
  assign chain_error_status_n   = status_oe ? status_out : 1'b1;
  assign configuration_finished = done_oe ? done_out : 1'b1;

  modport device_mp
  (
    input  config_request_n, serial_config_clock, serial_config_data, user_init_clock, chain_enable_in_n,
    input  chain_error_status_n, configuration_finished,
    output status_out, status_oe, done_out, done_oe, chain_enable_out_n
  );

  modport host_mp
  (
    output config_request_n, serial_config_clock, serial_config_data, user_init_clock, chain_enable_in_n,
    input  chain_error_status_n, configuration_finished
  );
endinterface

// file: logic/config_chain_map.svh
// Offsets, field positions, reset values and timing counts of the chain controller
`ifndef CONFIG_CHAIN_MAP_SVH
`define CONFIG_CHAIN_MAP_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS          10
`define RESTART_TIMEOUT_NS     40000
`define RESTART_TIMEOUT_CYCLES (`RESTART_TIMEOUT_NS / `CLK_PERIOD_NS)
`define CONFIG_LOW_NS          2000
`define CONFIG_LOW_CYCLES      ((`CONFIG_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IMAGE_BITS_DEFAULT     64
`define INIT_CYCLES_DEFAULT    64
`define INIT_EXTRA_DEFAULT     80
`define SCLK_HALF_DEFAULT      8

// ****************************************
// Host register map
// ****************************************
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_DATA      8'h08
`define REG_IRQ_STAT  8'h0C
`define REG_IRQ_CLR   8'h10
`define REG_IRQ_EN    8'h14
`define CTRL_START    0
`define CTRL_AUTO     1
`define CTRL_USERCLK  2
`define IRQ_BYTE      0
`define IRQ_ERROR     1
`define IRQ_USER      2
`define IRQ_RESTART   3
`define CTRL_RESET    2'h0
`define IRQ_EN_RESET  4'h0

`endif

// file: logic/config_chain_pkg.sv
// Types shared by both ends of the configuration chain
package config_chain_pkg;

  typedef enum logic [2:0]
  {
    DEV_RESET   = 3'h0,
    DEV_LOAD    = 3'h1,
    DEV_INIT    = 3'h3,
    DEV_USER    = 3'h2,
    DEV_ERROR   = 3'h6,
    DEV_HALT    = 3'h7,
    DEV_RESTART = 3'h5
  } dev_state_t;

  typedef enum logic [2:0]
  {
    H_IDLE  = 3'h0,
    H_PULSE = 3'h1,
    H_WAIT  = 3'h3,
    H_SHIFT = 3'h2,
    H_INIT  = 3'h6,
    H_DONE  = 3'h7,
    H_ERROR = 3'h5
  } host_state_t;

endpackage

// file: verification/serial_config_chain_control_bench.sv
// Bench: host and one device joined by the configuration lines
`timescale 1ns/1ps
`include "config_chain_map.svh"
module serial_config_chain_control_bench
  import config_chain_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        irq;
  logic        auto_rst = 1'b0;
  logic        user_sel = 1'b0;
  logic        user_mode;
  logic        cfg_err;
  logic [31:0] rd_val = 32'h0;
  logic [15:0] cap_reg = 16'h0;
  int          cap_cnt = 0;
  logic        sclk_q = 1'b0;
  logic        uclk_q = 1'b0;
  logic        req_q = 1'b1;
  int          uclk_rises = 0;
  int          req_falls = 0;
  int          mark = 0;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  config_chain_if link ();

  config_chain_host #(.SCLK_HALF(4), .INIT_EXTRA(10)) u_config_chain_host
  (
    .REF_CLK_I (clk),
    .RST_I     (rst),
    .LINK      (link.host_mp),
    .ADDR_I    (addr),
    .WDATA_I   (wdata),
    .WR_I      (wr),
    .RD_I      (rd),
    .RDATA_O   (rdata),
    .IRQ_O     (irq)
  );

  config_chain_device #(.IMAGE_BITS(16), .INIT_CYCLES(8)) u_config_chain_device
  (
    .REF_CLK_I       (clk),
    .RST_I           (rst),
    .LINK            (link.device_mp),
    .AUTO_RESTART_I  (auto_rst),
    .USER_INIT_SEL_I (user_sel),
    .USER_MODE_O     (user_mode),
    .CONFIG_ERROR_O  (cfg_err)
  );

  serial_config_chain_control_chk u_serial_config_chain_control_chk
  (
    .REF_CLK_I              (clk),
    .RST_I                  (rst),
    .AUTO_RESTART_I         (auto_rst),
    .config_request_n       (link.config_request_n),
    .serial_config_clock    (link.serial_config_clock),
    .serial_config_data     (link.serial_config_data),
    .user_init_clock        (link.user_init_clock),
    .chain_enable_in_n      (link.chain_enable_in_n),
    .chain_enable_out_n     (link.chain_enable_out_n),
    .done_oe                (link.done_oe),
    .chain_error_status_n   (link.chain_error_status_n),
    .configuration_finished (link.configuration_finished)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  // Wire monitor: first 16 bits after each request, LSB first
  always @(posedge clk)
  begin
    sclk_q <= link.serial_config_clock;
    uclk_q <= link.user_init_clock;
    req_q  <= link.config_request_n;
    cycles <= cycles + 1;
    if (!link.config_request_n)
      cap_cnt <= 0;
    else if (link.serial_config_clock && !sclk_q && cap_cnt < 16)
    begin
      cap_reg <= {link.serial_config_data, cap_reg[15:1]};
      cap_cnt <= cap_cnt + 1;
    end
    if (link.user_init_clock && !uclk_q)
      uclk_rises <= uclk_rises + 1;
    if (!link.config_request_n && req_q)
      req_falls <= req_falls + 1;
    if (cycles == 60000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    check(rd_val, exp);
  endtask

  task automatic wait_state(input logic [2:0] st);
    int n;
    n = 0;
    rd_reg(`REG_STATUS);
    while (rd_val[2:0] !== st && n < 3000)
    begin
      rd_reg(`REG_STATUS);
      n++;
    end
    check({29'h0, rd_val[2:0]}, {29'h0, st});
  endtask

  // Holding byte accepts a new write only once it reads empty
  task automatic send_image(input logic [7:0] b0, input logic [7:0] b1);
    int n;
    for (int i = 0; i < 2; i++)
    begin
      wr_reg(`REG_DATA, {24'h0, (i == 0) ? b0 : b1});
      n = 0;
      rd_reg(`REG_STATUS);
      while (rd_val[4] !== 1'b0 && n < 200)
      begin
        rd_reg(`REG_STATUS);
        n++;
      end
      check({31'h0, rd_val[4]}, 32'h0);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`REG_CTRL, 32'h0);
    rd_chk(`REG_IRQ_EN, 32'h0);
    rd_chk(`REG_STATUS, 32'h20);
    wr_reg(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h0);
    rd_chk(`REG_IRQ_STAT, 32'h0);
    // Clean load, then raise, mask and clear the interrupt
    wr_reg(`REG_IRQ_EN, 32'hF);
    rd_chk(`REG_IRQ_EN, 32'hF);
    wr_reg(`REG_CTRL, 32'h1);
    rd_chk(`REG_CTRL, 32'h0);
    wait_state(H_SHIFT);
    send_image(8'h5A, 8'h3C);
    wait_state(H_DONE);
    check({16'h0, cap_reg}, 32'h3C5A);
    check({31'h0, user_mode}, 32'h1);
    check({31'h0, link.chain_enable_out_n}, 32'h0);
    rd_chk(`REG_STATUS, 32'h67);
    rd_chk(`REG_IRQ_STAT, 32'h5);
    check({31'h0, irq}, 32'h1);
    wr_reg(`REG_IRQ_EN, 32'h2);
    rd_chk(`REG_IRQ_STAT, 32'h5);
    check({31'h0, irq}, 32'h0);
    wr_reg(`REG_IRQ_CLR, 32'hF);
    // Parity error without auto restart: status stays low until a new request
    wr_reg(`REG_CTRL, 32'h1);
    wait_state(H_SHIFT);
    send_image(8'h01, 8'h00);
    wait_state(H_ERROR);
    check({31'h0, cfg_err}, 32'h1);
    check({31'h0, irq}, 32'h1);
    rd_chk(`REG_IRQ_STAT, 32'h3);
    repeat (4500) @(posedge clk);
    check({31'h0, link.chain_error_status_n}, 32'h0);
    wr_reg(`REG_IRQ_CLR, 32'hF);
    wr_reg(`REG_CTRL, 32'h1);
    wait_state(H_SHIFT);
    check({31'h0, cfg_err}, 32'h0);
    send_image(8'h5A, 8'h3C);
    wait_state(H_DONE);
    // Parity error with auto restart: no request pulse, whole image again
    @(posedge clk);
    auto_rst <= 1'b1;
    wr_reg(`REG_IRQ_CLR, 32'hF);
    wr_reg(`REG_CTRL, 32'h3);
    wait_state(H_SHIFT);
    mark = req_falls;
    send_image(8'h01, 8'h00);
    wait_state(H_ERROR);
    wait_state(H_SHIFT);
    check(req_falls, mark);
    rd_chk(`REG_IRQ_STAT, 32'hB);
    send_image(8'h5A, 8'h3C);
    wait_state(H_DONE);
    // Initialisation clocked from the user clock line
    @(posedge clk);
    user_sel <= 1'b1;
    wr_reg(`REG_CTRL, 32'h5);
    wait_state(H_SHIFT);
    mark = uclk_rises;
    send_image(8'h5A, 8'h3C);
    wait_state(H_DONE);
    check({31'h0, user_mode}, 32'h1);
    check({31'h0, (uclk_rises - mark) >= 8}, 32'h1);
    print_verdict();
  end
endmodule

// file: verification/serial_config_chain_control_chk.sv
// Assertion checker on the lines between host and device
`timescale 1ns/1ps
`include "config_chain_map.svh"
module serial_config_chain_control_chk
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic AUTO_RESTART_I,
  input wire logic config_request_n,
  input wire logic serial_config_clock,
  input wire logic serial_config_data,
  input wire logic user_init_clock,
  input wire logic chain_enable_in_n,
  input wire logic chain_enable_out_n,
  input wire logic done_oe,
  input wire logic chain_error_status_n,
  input wire logic configuration_finished
);
  localparam int LOW_MIN  = `CONFIG_LOW_CYCLES;
  localparam int STAT_MAX = `RESTART_TIMEOUT_CYCLES + 10;

  // ****************************************
  // Helper counters
  // ****************************************
  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;
  logic [15:0] stat_cnt_reg;
  logic [15:0] stat_cnt_next;

  // Status low while request is high is an error hold, not a reset
  assign low_cnt_next  = config_request_n ? 16'h0000 : low_cnt_reg + 16'h0001;
  assign stat_cnt_next = (!chain_error_status_n && config_request_n) ? stat_cnt_reg + 16'h0001 : 16'h0000;

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      low_cnt_reg  <= 16'h0000;
      stat_cnt_reg <= 16'h0000;
    end
    else
    begin
      low_cnt_reg  <= low_cnt_next;
      stat_cnt_reg <= stat_cnt_next;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_request_fall;
    $fell(config_request_n);
  endsequence
  sequence s_status_stuck;
    (!chain_error_status_n && config_request_n) [*8];
  endsequence
  sequence s_init_edge;
    $rose(serial_config_clock) || $rose(user_init_clock);
  endsequence

  a_request_width: assert property ($rose(config_request_n) |-> low_cnt_reg >= LOW_MIN)
    else $error("request pulse too short");
  a_request_status: assert property (s_request_fall |-> ##[1:6] !chain_error_status_n)
    else $error("status not pulled during request");
  a_status_release: assert property ($rose(config_request_n) |-> ##[1:10] chain_error_status_n)
    else $error("status not released after request");
  a_error_parks: assert property (s_status_stuck |-> !serial_config_clock)
    else $error("serial clock runs while status low");
  a_restart_bound: assert property (AUTO_RESTART_I |-> stat_cnt_reg <= STAT_MAX)
    else $error("status held past restart timeout");
  a_first_enable: assert property (!chain_enable_in_n)
    else $error("first chain enable not low");
  a_enable_follows: assert property ($fell(done_oe) |-> ##[0:2] !chain_enable_out_n)
    else $error("chain enable out not driven low");
  a_init_clocking: assert property ($rose(configuration_finished) |-> ##[1:40] s_init_edge)
    else $error("no init clocking after done");
  a_clock_high: assert property ($rose(serial_config_clock) |-> serial_config_clock [*4])
    else $error("serial clock high phase short");
  a_data_steady: assert property (serial_config_clock && $past(serial_config_clock) |-> $stable(serial_config_data))
    else $error("data moved while clock high");
endmodule
